// *** include/ppo_regs.svh ***
// register map, reset values and timing constants of the port power block
// Summary of operation
// - 8-bit double-pulse window timer in 1 ms steps; second low pulse inside it flags.
// - double-pulse window register resets to 20 ms.
// - overcurrent is ignored for the ignore time right after power turns on.
// - ignore timer counts 1 ms steps and resets to 10 ms.
// - power disabled: the shared pin is actively driven low, except in ganged mode, where it is left undriven.
// - power enabled: driver off, pull-up on, pin becomes open drain.
// - power enabled: a low read on the pin feeds overcurrent detection.
// - one shared pin per port carries power enable and overcurrent sense.
// - port split is possible only on downstream ports 5 and 6.
// - split is configured only during the configuration stage.
// - with split on, the shared pin still controls the USB 2.0 half unchanged.
// - with split on, an extra output drives the SuperSpeed half's power.
// - no overcurrent detection on the split SuperSpeed power output.
// - split output pin: port 5 option A/B, port 6 option A/B.
// - continuous low for the minimum width (0 to 5 ms, default 5) flags.
// - while enabled, the pin is sampled continuously for all decisions.
// - ganged mode: overcurrent on the common pin flags every port.
`ifndef PPO_REGS_SVH
`define PPO_REGS_SVH
`define PPO_NPORTS        7
`define PPO_ADDR_LOCKOUT  16'h30e1
`define PPO_ADDR_MINW     16'h30ea
`define PPO_ADDR_WINDOW   16'h30eb
`define PPO_RST_LOCKOUT   8'h0a
`define PPO_RST_WINDOW    8'h14
`define PPO_RST_MINW      4'h5
`define PPO_MINW_MAX      4'h5
`define PPO_IDX_P5        3'h4
`define PPO_IDX_P6        3'h5
`define PPO_TICK_NS       1000000
`define PPO_CLK_NS        100
`endif

// *** include/ppo_pkg.sv ***
// types shared by the port power block
`include "ppo_regs.svh"
package ppo_pkg;
  typedef enum logic [1:0] {ppo_st_off, ppo_st_lock, ppo_st_watch} ppo_state_e;
  typedef logic [`PPO_NPORTS-1:0] ppo_port_t;
endpackage

// *** include/ppo_tmr_if.sv ***
// timer settings and millisecond tick handed to the detectors
`timescale 1ns/1ps
`default_nettype none
interface ppo_tmr_if;
  logic       tick;
  logic [7:0] lockout_ms;
  logic [7:0] window_ms;
  logic [3:0] min_width_ms;
  modport src (output tick, output lockout_ms, output window_ms, output min_width_ms);
  modport dst (input tick, input lockout_ms, input window_ms, input min_width_ms);
endinterface
`default_nettype wire

// *** hdl/ppo_tick.sv ***
// millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
module ppo_tick #(
  parameter int unsigned CYCLES = 10000
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt_r >= 32'(CYCLES - 1))
      begin
        cnt_r <= 32'h0;
        tick  <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + 32'h1;
        tick  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/ppo_ocs.sv ***
// overcurrent detector for one shared power/sense pin
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"
module ppo_ocs (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pwr_on,
  input  wire logic sense_low,
  ppo_tmr_if.dst    tmr,
  output logic      oc_evt
);
  ppo_pkg::ppo_state_e state_r;
  logic [7:0] lock_cnt_r;
  logic [7:0] win_cnt_r;
  logic [3:0] width_cnt_r;
  logic [3:0] width_nxt;
  logic       armed_r;
  logic       fired_r;
  logic       low_d_r;
  logic       low_start;
  logic       low_end;
  logic       single_hit;
  logic       evt_nxt;
  logic       watching;

  assign watching  = (state_r == ppo_pkg::ppo_st_watch);
  assign low_start = sense_low && !low_d_r;
  assign low_end   = !sense_low && low_d_r;

  always_comb
  begin
    width_nxt  = width_cnt_r + {3'h0, tmr.tick};
    single_hit = 1'b0;
    if (sense_low && !fired_r)
    begin
      if (tmr.min_width_ms == 4'h0)
        single_hit = 1'b1;
      else
        single_hit = (width_nxt >= tmr.min_width_ms);
    end
    evt_nxt = watching && (single_hit || (armed_r && low_start));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r    <= ppo_pkg::ppo_st_off;
      lock_cnt_r <= 8'h0;
    end
    else if (ce)
    begin
      if (!pwr_on)
        state_r <= ppo_pkg::ppo_st_off;
      else
        case (state_r)
          ppo_pkg::ppo_st_off:
          begin
            state_r    <= ppo_pkg::ppo_st_lock;
            lock_cnt_r <= tmr.lockout_ms;
          end
          ppo_pkg::ppo_st_lock:
          begin
            // a zero setting still gives one tick of ignore
            if (tmr.tick)
            begin
              if (lock_cnt_r <= 8'h1)
                state_r <= ppo_pkg::ppo_st_watch;
              else
                lock_cnt_r <= lock_cnt_r - 8'h1;
            end
          end
          ppo_pkg::ppo_st_watch: state_r <= ppo_pkg::ppo_st_watch;
          default: state_r <= ppo_pkg::ppo_st_off;
        endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      low_d_r     <= 1'b0;
      width_cnt_r <= 4'h0;
      fired_r     <= 1'b0;
    end
    else if (ce)
    begin
      low_d_r <= sense_low && watching;
      if (!watching || !sense_low)
      begin
        width_cnt_r <= 4'h0;
        fired_r     <= 1'b0;
      end
      else
      begin
        if (width_nxt < `PPO_MINW_MAX)
          width_cnt_r <= width_nxt;
        else
          width_cnt_r <= `PPO_MINW_MAX;
        if (evt_nxt)
          fired_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      armed_r   <= 1'b0;
      win_cnt_r <= 8'h0;
    end
    else if (ce)
    begin
      if (!watching)
        armed_r <= 1'b0;
      else if (armed_r)
      begin
        if (low_start)
          armed_r <= 1'b0;
        else if (tmr.tick)
        begin
          if (win_cnt_r <= 8'h1)
            armed_r <= 1'b0;
          else
            win_cnt_r <= win_cnt_r - 8'h1;
        end
      end
      else if (low_end)
      begin
        armed_r   <= 1'b1;
        win_cnt_r <= tmr.window_ms;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      oc_evt <= 1'b0;
    else if (ce)
      oc_evt <= evt_nxt;
  end
endmodule
`default_nettype wire

// *** hdl/ppo_top.sv ***
// downstream port power control, overcurrent sensing and port split outputs
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"
module ppo_top #(
  parameter int unsigned TICK_CYCLES = `PPO_TICK_NS / `PPO_CLK_NS
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        cfg_wr,
  input  wire logic [15:0]                 cfg_addr,
  input  wire logic [7:0]                  cfg_wdata,
  output logic      [7:0]                  cfg_rdata,
  input  wire logic                        cfg_stage,
  input  wire logic                        ganged_mode,
  input  wire logic                        split_en_p5,
  input  wire logic                        split_en_p6,
  input  wire logic                        split_opt_b_p5,
  input  wire logic                        split_opt_b_p6,
  input  wire logic [`PPO_NPORTS-1:0]      port_power_en,
  input  wire logic [1:0]                  ss_power_en,
  input  wire logic [`PPO_NPORTS-1:0]      oc_clear,
  input  wire logic [`PPO_NPORTS-1:0]      port_power_sense_pin_in,
  output logic      [`PPO_NPORTS-1:0]      port_power_sense_pin_out,
  output logic      [`PPO_NPORTS-1:0]      port_power_sense_pin_oe,
  output logic      [`PPO_NPORTS-1:0]      port_pullup_en,
  input  wire logic                        common_power_sense_pin_in,
  output logic                             common_power_sense_pin_out,
  output logic                             common_power_sense_pin_oe,
  output logic                             common_pullup_en,
  output logic                             superspeed_split_power_pin_p5a_out,
  output logic                             superspeed_split_power_pin_p5a_oe,
  output logic                             superspeed_split_power_pin_p5b_out,
  output logic                             superspeed_split_power_pin_p5b_oe,
  output logic                             superspeed_split_power_pin_p6a_out,
  output logic                             superspeed_split_power_pin_p6a_oe,
  output logic                             superspeed_split_power_pin_p6b_out,
  output logic                             superspeed_split_power_pin_p6b_oe,
  output logic      [`PPO_NPORTS-1:0]      oc_status
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0]           lockout_r;
  logic [7:0]           window_r;
  logic [3:0]           min_width_r;
  logic [3:0]           min_width_nxt;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // out-of-range values in the low four bits clamp to the longest setting; the upper four bits are dropped
  always_comb
  begin
    if (cfg_wdata[3:0] > `PPO_MINW_MAX)
      min_width_nxt = `PPO_MINW_MAX;
    else
      min_width_nxt = cfg_wdata[3:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lockout_r   <= `PPO_RST_LOCKOUT;
      window_r    <= `PPO_RST_WINDOW;
      min_width_r <= `PPO_RST_MINW;
    end
    else if (ce && cfg_wr)
    begin
      // zero is stored as written; lockout and window treat it as one tick, a zero minimum width flags at once
      if (addr_hit(cfg_addr, `PPO_ADDR_LOCKOUT))
        lockout_r <= cfg_wdata;
      if (addr_hit(cfg_addr, `PPO_ADDR_WINDOW))
        window_r <= cfg_wdata;
      if (addr_hit(cfg_addr, `PPO_ADDR_MINW))
        min_width_r <= min_width_nxt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cfg_rdata <= 8'h0;
    else if (ce)
    begin
      if (addr_hit(cfg_addr, `PPO_ADDR_LOCKOUT))
        cfg_rdata <= lockout_r;
      else if (addr_hit(cfg_addr, `PPO_ADDR_WINDOW))
        cfg_rdata <= window_r;
      else if (addr_hit(cfg_addr, `PPO_ADDR_MINW))
        cfg_rdata <= {4'h0, min_width_r};
      else
        cfg_rdata <= 8'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration-stage straps: mode and split setup

  logic ganged_r;
  logic split_p5_r;
  logic split_p6_r;
  logic opt_b_p5_r;
  logic opt_b_p6_r;

  // frozen outside the configuration stage, so a live port never re-maps
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ganged_r   <= 1'b0;
      split_p5_r <= 1'b0;
      split_p6_r <= 1'b0;
      opt_b_p5_r <= 1'b0;
      opt_b_p6_r <= 1'b0;
    end
    else if (ce && cfg_stage)
    begin
      ganged_r   <= ganged_mode;
      split_p5_r <= split_en_p5;
      split_p6_r <= split_en_p6;
      opt_b_p5_r <= split_opt_b_p5;
      opt_b_p6_r <= split_opt_b_p6;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [`PPO_NPORTS-1:0] pin_s1_r;
  logic [`PPO_NPORTS-1:0] pin_s2_r;
  logic                   com_s1_r;
  logic                   com_s2_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      com_s1_r <= 1'b1;
      com_s2_r <= 1'b1;
    end
    else if (ce)
    begin
      pin_s1_r <= port_power_sense_pin_in;
      pin_s2_r <= pin_s1_r;
      com_s1_r <= common_power_sense_pin_in;
      com_s2_r <= com_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick and detectors

  ppo_tmr_if tmr ();

  ppo_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .tick    (tmr.tick)
  );

  assign tmr.lockout_ms   = lockout_r;
  assign tmr.window_ms    = window_r;
  assign tmr.min_width_ms = min_width_r;

  ppo_pkg::ppo_port_t     port_pwr;
  ppo_pkg::ppo_port_t     port_evt;
  logic                   common_power_sense_pin;
  logic                   gang_evt;

  // in ganged mode the individual pins stay off and the common pin takes over
  assign port_pwr = ganged_r ? '0 : port_power_en;
  assign common_power_sense_pin = ganged_r && (|port_power_en);

  generate
    for (genvar i = 0; i < `PPO_NPORTS; i++)
    begin : g_port
      ppo_ocs u_ocs (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pwr_on    (port_pwr[i]),
        .sense_low (!pin_s2_r[i]),
        .tmr       (tmr),
        .oc_evt    (port_evt[i])
      );
    end
  endgenerate

  ppo_ocs u_ocs_gang (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pwr_on    (common_power_sense_pin),
    .sense_low (!com_s2_r),
    .tmr       (tmr),
    .oc_evt    (gang_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent status

  ppo_pkg::ppo_port_t oc_set;

  assign oc_set = port_evt | {`PPO_NPORTS{gang_evt}};

  // a new event in the clearing cycle keeps the flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      oc_status <= '0;
    else if (ce)
      oc_status <= (oc_status & ~oc_clear) | oc_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pin drivers

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      port_power_sense_pin_out <= '0;
      port_power_sense_pin_oe  <= '1;
      port_pullup_en           <= '0;
    end
    else if (ce)
    begin
      // split ports use this same path: USB 2.0 half unchanged
      port_power_sense_pin_out <= '0;
      // ganged pins may be tied to the common pin, so never drive them then
      port_power_sense_pin_oe  <= ganged_r ? '0 : ~port_pwr;
      port_pullup_en           <= port_pwr;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      common_power_sense_pin_out <= 1'b0;
      common_power_sense_pin_oe  <= 1'b0;
      common_pullup_en           <= 1'b0;
    end
    else if (ce)
    begin
      // outside ganged mode the common pin is left undriven
      common_power_sense_pin_out <= 1'b0;
      common_power_sense_pin_oe  <= ganged_r && !common_power_sense_pin;
      common_pullup_en           <= common_power_sense_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SuperSpeed split power outputs, no sensing on these pins

  logic ss_p5_on;
  logic ss_p6_on;

  assign ss_p5_on = split_p5_r && ss_power_en[0];
  assign ss_p6_on = split_p6_r && ss_power_en[1];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      superspeed_split_power_pin_p5a_out <= 1'b0;
      superspeed_split_power_pin_p5a_oe  <= 1'b0;
      superspeed_split_power_pin_p5b_out <= 1'b0;
      superspeed_split_power_pin_p5b_oe  <= 1'b0;
    end
    else if (ce)
    begin
      superspeed_split_power_pin_p5a_out <= ss_p5_on;
      superspeed_split_power_pin_p5a_oe  <= split_p5_r && !opt_b_p5_r;
      superspeed_split_power_pin_p5b_out <= ss_p5_on;
      superspeed_split_power_pin_p5b_oe  <= split_p5_r && opt_b_p5_r;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      superspeed_split_power_pin_p6a_out <= 1'b0;
      superspeed_split_power_pin_p6a_oe  <= 1'b0;
      superspeed_split_power_pin_p6b_out <= 1'b0;
      superspeed_split_power_pin_p6b_oe  <= 1'b0;
    end
    else if (ce)
    begin
      superspeed_split_power_pin_p6a_out <= ss_p6_on;
      superspeed_split_power_pin_p6a_oe  <= split_p6_r && !opt_b_p6_r;
      superspeed_split_power_pin_p6b_out <= ss_p6_on;
      superspeed_split_power_pin_p6b_oe  <= split_p6_r && opt_b_p6_r;
    end
  end

endmodule
`default_nettype wire

// *** tb/ppo_switch_model.sv ***
// external power switches or poly fuses on the shared and common power/sense pins
`timescale 1ns/1ps
`default_nettype none
module ppo_switch_model #(
  parameter int unsigned N = 8
) (
  input  wire logic         ref_clk,
  input  wire logic [N-1:0] drive_low,
  input  wire logic [N-1:0] pull_en,
  input  wire logic [N-1:0] fault,
  output wire logic [N-1:0] pin
);
  // an undriven node without pull-up has no fixed level, so it wanders each cycle
  logic [N-1:0] float_r = '0;
  always @(posedge ref_clk)
    float_r <= ~float_r;
  // the switch pulls its open-drain flag low on overcurrent
  assign pin = ~drive_low & ~fault & (pull_en | float_r);
endmodule
`default_nettype wire

// *** tb/ppo_top_assertions.sv ***
// concurrent checks on the ports of the port power block
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"
module ppo_top_assertions (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        cfg_stage,
  input wire logic        ganged_mode,
  input wire logic        split_en_p5,
  input wire logic        split_opt_b_p5,
  input wire logic [6:0]  port_power_en,
  input wire logic [1:0]  ss_power_en,
  input wire logic [6:0]  oc_clear,
  input wire logic [6:0]  port_power_sense_pin_out,
  input wire logic [6:0]  port_power_sense_pin_oe,
  input wire logic [6:0]  port_pullup_en,
  input wire logic        common_power_sense_pin_oe,
  input wire logic        common_pullup_en,
  input wire logic        superspeed_split_power_pin_p5a_out,
  input wire logic        superspeed_split_power_pin_p5a_oe,
  input wire logic        superspeed_split_power_pin_p5b_out,
  input wire logic        superspeed_split_power_pin_p5b_oe,
  input wire logic [6:0]  oc_status
);
  logic gang_r;
  logic sp5_r;
  logic ob5_r;
  // mirror of the straps, which move only in the configuration stage
  always_ff @(posedge ref_clk)
    if (!rst_n)
      {gang_r, sp5_r, ob5_r} <= 3'h0;
    else if (ce && cfg_stage)
      {gang_r, sp5_r, ob5_r} <= {ganged_mode, split_en_p5, split_opt_b_p5};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  pin_drive_off_a: assert property (ce && !gang_r |=>
    port_power_sense_pin_oe == ~$past(port_power_en) && port_power_sense_pin_out == '0)
    else $error("shared pin drive does not follow power request");
  pullup_on_a: assert property (ce && !gang_r |=> port_pullup_en == $past(port_power_en))
    else $error("pull-up does not follow power request");
  gang_release_a: assert property (ce && gang_r |=> port_power_sense_pin_oe == '0 &&
    common_power_sense_pin_oe == !(|$past(port_power_en)) && common_pullup_en == |$past(port_power_en))
    else $error("ganged pin control wrong");
  status_sticky_a: assert property (ce |=>
    ($past(oc_status) & ~$past(oc_clear) & ~oc_status) == '0)
    else $error("overcurrent flag lost without clear");
  reg_write_read_a: assert property (ce && cfg_wr &&
    (cfg_addr == `PPO_ADDR_WINDOW || cfg_addr == `PPO_ADDR_LOCKOUT) ##1 ce && $stable(cfg_addr)
    |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("timer register readback wrong");
  width_clamp_a: assert property (ce && cfg_wr && cfg_addr == `PPO_ADDR_MINW &&
    cfg_wdata[7:4] == 4'h0 ##1 ce && $stable(cfg_addr) |=> cfg_rdata ==
    (($past(cfg_wdata, 2) > 8'h05) ? 8'h05 : $past(cfg_wdata, 2)))
    else $error("minimum width readback wrong");
  reset_outputs_a: assert property (disable iff (1'b0) !rst_n && ce |=>
    cfg_rdata == 8'h00 && port_power_sense_pin_oe == '1 && oc_status == '0)
    else $error("outputs wrong in reset");
  split_select_a: assert property (ce && sp5_r |=>
    superspeed_split_power_pin_p5b_oe == $past(ob5_r) && superspeed_split_power_pin_p5a_oe ==
    !$past(ob5_r) && (($past(ob5_r) ? superspeed_split_power_pin_p5b_out :
    superspeed_split_power_pin_p5a_out) == $past(ss_power_en[0])))
    else $error("split output selection wrong");
  split_off_a: assert property (ce && !sp5_r |=>
    !superspeed_split_power_pin_p5a_oe && !superspeed_split_power_pin_p5b_oe)
    else $error("split output active while disabled");
  write_seen_c: cover property (ce && cfg_wr);
  flag_seen_c: cover property ($rose(oc_status[1]));
  gang_seen_c: cover property (gang_r && |port_power_en);
endmodule
bind ppo_top ppo_top_assertions ppo_top_assertions_inst (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the port power block
`timescale 1ns/1ps
`default_nettype none
`include "ppo_regs.svh"
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        cfg_wr = 1'b0;
  logic [15:0] cfg_addr = 16'h0000;
  logic [7:0]  cfg_wdata = 8'h00;
  logic        cfg_stage = 1'b0;
  logic        ganged_mode = 1'b0;
  logic        split_en_p5 = 1'b0;
  logic        split_en_p6 = 1'b0;
  logic        split_opt_b_p5 = 1'b0;
  logic        split_opt_b_p6 = 1'b0;
  logic [6:0]  port_power_en = 7'h00;
  logic [1:0]  ss_power_en = 2'h0;
  logic [6:0]  oc_clear = 7'h00;
  logic [6:0]  fault = 7'h00;
  logic        cfault = 1'b0;
  wire  [6:0]  port_power_sense_pin_in;
  wire         common_power_sense_pin_in;
  logic [6:0]  port_power_sense_pin_out, port_power_sense_pin_oe, port_pullup_en, oc_status;
  logic [7:0]  cfg_rdata;
  logic        common_power_sense_pin_out, common_power_sense_pin_oe, common_pullup_en;
  logic        superspeed_split_power_pin_p5a_out, superspeed_split_power_pin_p5a_oe;
  logic        superspeed_split_power_pin_p5b_out, superspeed_split_power_pin_p5b_oe;
  logic        superspeed_split_power_pin_p6a_out, superspeed_split_power_pin_p6a_oe;
  logic        superspeed_split_power_pin_p6b_out, superspeed_split_power_pin_p6b_oe;
  int          fail_count = 0;
  int          checks_done = 0;
  // one millisecond is ten cycles here
  ppo_top #(.TICK_CYCLES(10)) ppo_top_inst (.*);
  ppo_switch_model ppo_switch_model_inst (
    .ref_clk   (ref_clk),
    .drive_low ({common_power_sense_pin_oe, port_power_sense_pin_oe}),
    .pull_en   ({common_pullup_en, port_pullup_en}),
    .fault     ({cfault, fault}),
    .pin       ({common_power_sense_pin_in, port_power_sense_pin_in})
  );
  always #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cfg_addr = a;
    cyc(1);
    chk(cfg_rdata, e);
  endtask
  task automatic pulse(input int i);
    fault[i] = 1'b1;
    cyc(5);
    fault[i] = 1'b0;
  endtask
  task automatic clear_all;
    oc_clear = 7'h7f;
    cyc(1);
    oc_clear = 7'h00;
    cyc(1);
    chk({1'b0, oc_status}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({1'b0, port_power_sense_pin_oe}, 8'h7f);
    chk({1'b0, port_pullup_en}, 8'h00);
    chk({4'h0, superspeed_split_power_pin_p5a_oe, superspeed_split_power_pin_p5b_oe,
      superspeed_split_power_pin_p6a_oe, superspeed_split_power_pin_p6b_oe}, 8'h00);
    rd(16'h30e1, 8'h0a);
    rd(16'h30eb, 8'h14);
    rd(16'h30ea, 8'h05);
  endtask
  task automatic t_regs;
    wr(16'h30ec, 8'h55);
    rd(16'h30ec, 8'h00);
    wr(16'h30ea, 8'h09);
    rd(16'h30ea, 8'h05);
    wr(16'h30ea, 8'h02);
    rd(16'h30ea, 8'h02);
    // timers kept nonzero, and short to keep the run brief
    wr(16'h30e1, 8'h03);
    rd(16'h30e1, 8'h03);
    wr(16'h30eb, 8'h02);
    rd(16'h30eb, 8'h02);
  endtask
  task automatic t_single;
    port_power_en[0] = 1'b1;
    cyc(1);
    chk({1'b0, port_power_sense_pin_oe}, 8'h7e);
    chk({1'b0, port_pullup_en}, 8'h01);
    cyc(40);
    fault[0] = 1'b1;
    cyc(8);
    chk({1'b0, oc_status}, 8'h00);
    cyc(30);
    chk({1'b0, oc_status}, 8'h01);
    fault[0] = 1'b0;
    cyc(8);
    clear_all();
    port_power_en[0] = 1'b0;
    fault[0] = 1'b1;
    cyc(1);
    chk({1'b0, port_power_sense_pin_oe}, 8'h7f);
    chk({1'b0, port_pullup_en}, 8'h00);
    cyc(60);
    chk({1'b0, oc_status}, 8'h00);
    fault[0] = 1'b0;
  endtask
  task automatic t_double;
    port_power_en[1] = 1'b1;
    fault[1] = 1'b1;
    cyc(15);
    fault[1] = 1'b0;
    cyc(40);
    chk({1'b0, oc_status}, 8'h00);
    pulse(1);
    cyc(40);
    chk({1'b0, oc_status}, 8'h00);
    pulse(1);
    cyc(8);
    pulse(1);
    cyc(6);
    chk({1'b0, oc_status}, 8'h02);
    port_power_en[1] = 1'b0;
    cyc(8);
    clear_all();
  endtask
  task automatic t_gang;
    cfg_stage = 1'b1;
    ganged_mode = 1'b1;
    cyc(2);
    cfg_stage = 1'b0;
    ganged_mode = 1'b0;
    cyc(2);
    chk({1'b0, port_power_sense_pin_oe}, 8'h00);
    chk({7'h00, common_power_sense_pin_oe}, 8'h01);
    chk({7'h00, common_power_sense_pin_out}, 8'h00);
    port_power_en = 7'h04;
    cyc(1);
    chk({6'h00, common_power_sense_pin_oe, common_pullup_en}, 8'h01);
    cyc(40);
    cfault = 1'b1;
    cyc(40);
    chk({1'b0, oc_status}, 8'h7f);
    cfault = 1'b0;
    port_power_en = 7'h00;
    cfg_stage = 1'b1;
    cyc(2);
    cfg_stage = 1'b0;
    cyc(8);
    clear_all();
  endtask
  task automatic t_split(input logic b5, input logic b6);
    cfg_stage = 1'b1;
    split_en_p5 = 1'b1;
    split_en_p6 = 1'b1;
    split_opt_b_p5 = b5;
    split_opt_b_p6 = b6;
    cyc(2);
    cfg_stage = 1'b0;
    // straps moved outside the stage must change nothing
    split_en_p5 = 1'b0;
    split_opt_b_p5 = ~b5;
    ss_power_en = 2'h3;
    port_power_en = 7'h10;
    cyc(2);
    chk({4'h0, superspeed_split_power_pin_p5a_oe, superspeed_split_power_pin_p5b_oe,
      superspeed_split_power_pin_p6a_oe, superspeed_split_power_pin_p6b_oe},
      {4'h0, ~b5, b5, ~b6, b6});
    chk({6'h00, b5 ? superspeed_split_power_pin_p5b_out : superspeed_split_power_pin_p5a_out,
      b6 ? superspeed_split_power_pin_p6b_out : superspeed_split_power_pin_p6a_out}, 8'h03);
    chk({1'b0, port_power_sense_pin_oe}, 8'h6f);
    ss_power_en = 2'h0;
    port_power_en = 7'h00;
    cyc(2);
    chk({6'h00, b5 ? superspeed_split_power_pin_p5b_out : superspeed_split_power_pin_p5a_out,
      b6 ? superspeed_split_power_pin_p6b_out : superspeed_split_power_pin_p6a_out}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(12);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_single();
    t_double();
    t_gang();
    t_split(1'b0, 1'b1);
    t_split(1'b1, 1'b0);
    test_done();
  end
  // the tests need under a thousand cycles; five thousand means a hang
  initial
  begin
    #500000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
